// File: rtl/filin_top.sv
// filter input load stage: sample broadcast, cell zero coefficient, register view
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
module filin_top
  import filin_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  sample_in_bus_i,
  input  wire logic        sample_format_sel_i,
  input  wire logic        sample_load_en_n_i,
  input  wire logic [7:0]  coef_in_bus_i,
  input  wire logic        coef_format_sel_i,
  input  wire logic        coef_load_en_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic [71:0]      sample_cells_o,
  output logic [8:0]       coef_cell0_o
);
`include "filin_defines.svh"

  // delayed enables
  logic        samp_en_n_r;
  logic        coef_en_n_r;
  filin_cidx_t view_sel_r;
  filin_cidx_t view_sel_nxt;

  filin_opnd_t samp_bus_in;
  filin_opnd_t coef_bus_in;
  filin_opnd_t samp_q [`FILIN_CELLS];
  filin_opnd_t coef_q;
  filin_opnd_t sel_samp;
  filin_word_t sel_samp_val;
  filin_word_t coef_val;
  filin_word_t status_word;
  filin_word_t rd_mux;
  logic        bus_wr;
  logic        bus_rd;
  filin_ofs_t  bus_addr;
  logic        wr_ctrl;
  logic        rd_take;
  filin_ofs_t  rd_ofs;
  filin_word_t hrdata_r;

  // format-aware widening of an operand for software readback
  function automatic filin_word_t filin_widen(input filin_opnd_t v);
    filin_word_t w;
    w = {24'h000000, v[7:0]};
    if (v[`FILIN_FMT_BIT] && v[`FILIN_SIGN_BIT]) begin
      w = {24'hFFFFFF, v[7:0]};
    end
    return w;
  endfunction

  // the pins come from logic on this same clock, so no synchroniser here;
  // a stray asynchronous source would need one ahead of this block
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      samp_en_n_r <= `FILIN_EN_N_RST;
      coef_en_n_r <= `FILIN_EN_N_RST;
    end else begin
      samp_en_n_r <= sample_load_en_n_i; // R07
      coef_en_n_r <= coef_load_en_n_i;   // R10
    end
  end

  // flag rides with the data on both internal buses
  assign samp_bus_in = {sample_format_sel_i, sample_in_bus_i}; // R04 R14
  assign coef_bus_in = {coef_format_sel_i, coef_in_bus_i};     // R12 R14

  // one shared bus feeds every cell so they load together
  genvar gi;
  generate
    for (gi = 0; gi < `FILIN_CELLS; gi++) begin : g_cell
      filin_cell_reg u_samp (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .load_i    (1'b1),
        .zero_i    (samp_en_n_r),   // R06
        .d_i       (samp_bus_in),   // R01 R02 R05
        .q_o       (samp_q[gi])
      );
      assign sample_cells_o[gi*9 +: 9] = samp_q[gi];
    end
  endgenerate

  filin_cell_reg u_coef (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .load_i    (!coef_en_n_r),     // R09 R13
    .zero_i    (1'b0),
    .d_i       (coef_bus_in),
    .q_o       (coef_q)
  );
  assign coef_cell0_o = coef_q;

  // register bus
  filin_ahb_slv u_ahb (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .hsel_i    (hsel_i),
    .haddr_i   (haddr_i),
    .htrans_i  (htrans_i),
    .hwrite_i  (hwrite_i),
    .hsize_i   (hsize_i),
    .hready_i  (hready_i),
    .wr_o      (bus_wr),
    .rd_o      (bus_rd),
    .addr_o    (bus_addr)
  );

  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign wr_ctrl      = bus_wr && (bus_addr == `FILIN_OFS_CTRL);
  assign view_sel_nxt = wr_ctrl ? hwdata_i[`FILIN_CTRL_SEL_W-1:0] : view_sel_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      view_sel_r <= `FILIN_CTRL_RST;
    end else begin
      view_sel_r <= view_sel_nxt;
    end
  end

  // look-ahead select, so a read right behind a ctrl write sees the new cell
  assign sel_samp     = samp_q[view_sel_nxt];
  assign sel_samp_val = filin_widen(sel_samp); // R03
  assign coef_val     = filin_widen(coef_q);   // R11
  assign status_word  = {30'h00000000, coef_en_n_r, samp_en_n_r};
  assign rd_ofs       = haddr_i[7:0];
  assign rd_take      = hsel_i && hready_i && htrans_i[1] && !hwrite_i && (hsize_i == `FILIN_HSIZE_WORD);

  // read data is picked in the address phase and held in a flop for the data phase;
  // unmapped offsets read zero, response stays okay
  assign rd_mux = (rd_ofs == `FILIN_OFS_CTRL)   ? {29'h00000000, view_sel_nxt} :
                  (rd_ofs == `FILIN_OFS_STATUS) ? status_word :
                  (rd_ofs == `FILIN_OFS_SVIEW)  ? {23'h000000, sel_samp} :
                  (rd_ofs == `FILIN_OFS_CVIEW)  ? {23'h000000, coef_q} :
                  (rd_ofs == `FILIN_OFS_SVAL)   ? sel_samp_val :
                  (rd_ofs == `FILIN_OFS_CVAL)   ? coef_val : 32'h00000000;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_r <= 32'h00000000;
    end else if (hready_i) begin
      hrdata_r <= rd_take ? rd_mux : 32'h00000000;
    end
  end

  assign hrdata_o = hrdata_r;

  // checks
  logic cells_equal;
  always_comb begin
    cells_equal = 1'b1;
    for (int i = 1; i < `FILIN_CELLS; i++) begin
      if (samp_q[i] != samp_q[0]) begin
        cells_equal = 1'b0;
      end
    end
  end

  sequence s_samp_armed;
    !sample_load_en_n_i ##1 1'b1;
  endsequence

  sequence s_samp_blocked;
    sample_load_en_n_i ##1 1'b1;
  endsequence

  sequence s_coef_armed;
    !coef_load_en_n_i ##1 1'b1;
  endsequence

  sequence s_coef_blocked;
    coef_load_en_n_i ##1 1'b1;
  endsequence

  property p_cells_equal;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      cells_equal;
  endproperty
  a_cells_equal: assert property (p_cells_equal) else $error("cells hold different samples"); // R01

  property p_samp_load;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_samp_armed |=> samp_q[`FILIN_CELLS-1][7:0] == $past(sample_in_bus_i);
  endproperty
  a_samp_load: assert property (p_samp_load) else $error("sample not loaded one clock after enable"); // R05

  property p_samp_fmt;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_samp_armed |=> samp_q[0][`FILIN_FMT_BIT] == $past(sample_format_sel_i);
  endproperty
  a_samp_fmt: assert property (p_samp_fmt) else $error("sample format flag not captured"); // R04

  property p_samp_zero;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_samp_blocked |=> samp_q[0] == `FILIN_CELL_RST;
  endproperty
  a_samp_zero: assert property (p_samp_zero) else $error("disabled sample load did not give zero"); // R06

  property p_samp_delay;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $fell(sample_load_en_n_i) |-> samp_en_n_r ##1 !samp_en_n_r;
  endproperty
  a_samp_delay: assert property (p_samp_delay) else $error("sample enable delay wrong"); // R07

  property p_samp_sync;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !$stable(samp_q[0]) |-> $past(!samp_en_n_r) || samp_q[0] == `FILIN_CELL_RST;
  endproperty
  a_samp_sync: assert property (p_samp_sync) else $error("sample changed without enable"); // R02

  property p_samp_sign;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      sel_samp_val[31:8] == ((sel_samp[`FILIN_FMT_BIT] && sel_samp[`FILIN_SIGN_BIT]) ? 24'hFFFFFF : 24'h000000);
  endproperty
  a_samp_sign: assert property (p_samp_sign) else $error("sample readback ignores format"); // R03

  property p_coef_load;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_coef_armed |=> coef_q == $past(coef_bus_in);
  endproperty
  a_coef_load: assert property (p_coef_load) else $error("coefficient not loaded one clock after enable"); // R09

  property p_coef_delay;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(coef_load_en_n_i) |-> !coef_en_n_r ##1 coef_en_n_r;
  endproperty
  a_coef_delay: assert property (p_coef_delay) else $error("coefficient enable delay wrong"); // R10

  property p_coef_fmt;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_coef_armed |=> coef_q[`FILIN_FMT_BIT] == $past(coef_format_sel_i);
  endproperty
  a_coef_fmt: assert property (p_coef_fmt) else $error("coefficient format flag not captured"); // R12

  property p_coef_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_coef_blocked |=> $stable(coef_q);
  endproperty
  a_coef_hold: assert property (p_coef_hold) else $error("coefficient changed while disabled"); // R13

  property p_coef_sign;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !coef_q[`FILIN_FMT_BIT] |-> coef_val[31:8] == 24'h000000;
  endproperty
  a_coef_sign: assert property (p_coef_sign) else $error("unsigned coefficient read back signed"); // R11

  property p_flag_kept;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_samp_armed |=> sample_cells_o[8] == $past(sample_format_sel_i)
                       && sample_cells_o[71] == $past(sample_format_sel_i);
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("cell lost its format flag"); // R14

  property p_samp_en_reg;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> samp_en_n_r == $past(sample_load_en_n_i);
  endproperty
  a_samp_en_reg: assert property (p_samp_en_reg) else $error("sample enable not registered"); // R07

  property p_coef_en_reg;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> coef_en_n_r == $past(coef_load_en_n_i);
  endproperty
  a_coef_en_reg: assert property (p_coef_en_reg) else $error("coefficient enable not registered"); // R10

  property p_samp_zero_all;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_samp_blocked |=> sample_cells_o == 72'h000000000000000000;
  endproperty
  a_samp_zero_all: assert property (p_samp_zero_all) else $error("a cell kept data while disabled"); // R06

  property p_coef_neg;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      coef_q[`FILIN_FMT_BIT] && coef_q[`FILIN_SIGN_BIT] |-> coef_val[31:8] == 24'hFFFFFF;
  endproperty
  a_coef_neg: assert property (p_coef_neg) else $error("signed coefficient not sign extended"); // R11

  property p_ctrl_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_ctrl |=> view_sel_r == $past(hwdata_i[`FILIN_CTRL_SEL_W-1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("cell select not written");

  property p_rd_idle;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !bus_rd |-> hrdata_o == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read data phase");

  sequence s_status_rd;
    rd_take && (rd_ofs == `FILIN_OFS_STATUS);
  endsequence

  property p_rd_status;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_status_rd |=> hrdata_o == {30'h00000000, $past(coef_load_en_n_i, 2), $past(sample_load_en_n_i, 2)};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read misses delayed enables"); // R07 R10
endmodule

// File: rtl/filin_defines.svh
// constants for the filter input load stage: offsets, fields, reset values
//
// Functional notes
// [R01] each sample loads into all eight cell sample registers on one edge
// [R02] sample loading happens only on rising clock edges, gated by load enable
// [R03] sample format low means unsigned, high means two's complement
// [R04] sample format flag is captured with the sample bits, same edge and enable
// [R05] enable effectively low: every cell sample register takes the 8-bit bus value
// [R06] enable effectively high: internal sample bus forced to zero, zeros loaded
// [R07] sample load enable is registered, acting exactly one clock late
// [R08] source drives sample enable low the cycle before presenting the sample
// [R09] coefficient loads into cell zero coefficient register while enable effectively low
// [R10] coefficient load enable is delayed one clock before gating the load
// [R11] coefficient format low means unsigned, high means two's complement
// [R12] coefficient format flag is captured with coefficient bits, same conditions
// [R13] coefficient enable effectively high: coefficient register holds, clock ignored
// [R14] every sample and coefficient register keeps a format flag beside eight bits
`ifndef FILIN_DEFINES_SVH
`define FILIN_DEFINES_SVH

`define FILIN_CELLS       8
`define FILIN_DW          8
`define FILIN_OPW         9
`define FILIN_FMT_BIT     8
`define FILIN_SIGN_BIT    7

`define FILIN_OFS_CTRL    8'h00
`define FILIN_OFS_STATUS  8'h04
`define FILIN_OFS_SVIEW   8'h08
`define FILIN_OFS_CVIEW   8'h0C
`define FILIN_OFS_SVAL    8'h10
`define FILIN_OFS_CVAL    8'h14

`define FILIN_CTRL_SEL_W  3
`define FILIN_ST_SEN_BIT  0
`define FILIN_ST_CEN_BIT  1

`define FILIN_EN_N_RST    1'b1
`define FILIN_CELL_RST    9'h000
`define FILIN_CTRL_RST    3'h0

`define FILIN_HTRANS_NSEQ 2'h2
`define FILIN_HSIZE_WORD  3'h2

`endif

// File: rtl/filin_pkg.sv
// types shared by the filter input load stage
package filin_pkg;
  typedef logic [8:0]  filin_opnd_t;
  typedef logic [2:0]  filin_cidx_t;
  typedef logic [31:0] filin_word_t;
  typedef logic [7:0]  filin_ofs_t;
endpackage

// File: rtl/filin_cell_reg.sv
// one operand register: flag plus data, with load and zero-force
module filin_cell_reg
  import filin_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        load_i,
  input  wire logic        zero_i,
  input  wire filin_opnd_t d_i,
  output filin_opnd_t      q_o
);
`include "filin_defines.svh"

  filin_opnd_t q_r;
  filin_opnd_t q_nxt;

  // zero-force wins over the data, but only while loading
  assign q_nxt = !load_i ? q_r :
                 zero_i  ? `FILIN_CELL_RST : d_i;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_r <= `FILIN_CELL_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule

// File: rtl/filin_ahb_slv.sv
// ahb-lite address phase capture for the register file, zero wait states
module filin_ahb_slv
  import filin_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  output logic             wr_o,
  output logic             rd_o,
  output filin_ofs_t       addr_o
);
`include "filin_defines.svh"

  logic       wr_r;
  logic       rd_r;
  filin_ofs_t addr_r;
  logic       take;

  // only single word transfers are honoured; others complete but do nothing
  assign take = hsel_i && hready_i && htrans_i[1] && (hsize_i == `FILIN_HSIZE_WORD);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready_i) begin
      wr_r   <= take && hwrite_i;
      rd_r   <= take && !hwrite_i;
      addr_r <= haddr_i[7:0];
    end
  end

  assign wr_o   = wr_r;
  assign rd_o   = rd_r;
  assign addr_o = addr_r;
endmodule

// File: bench/filin_src_model.sv
// sample and coefficient source model driving the load stage inputs
module filin_src_model
  import filin_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        s_req_i,
  input  wire filin_opnd_t s_val_i,
  input  wire logic        c_req_i,
  input  wire filin_opnd_t c_val_i,
  output logic [7:0]       sample_in_bus_o,
  output logic             sample_format_sel_o,
  output logic             sample_load_en_n_o,
  output logic [7:0]       coef_in_bus_o,
  output logic             coef_format_sel_o,
  output logic             coef_load_en_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  filin_opnd_t s_q;
  filin_opnd_t c_q;
  initial begin
    {sample_in_bus_o, sample_format_sel_o, sample_load_en_n_o} = '1;
    {coef_in_bus_o, coef_format_sel_o, coef_load_en_n_o} = '1;
  end
  // enable one cycle ahead of the data; idle bus toggles so stale values never match
  always @(posedge clk_sys_i) begin
    sample_load_en_n_o <= !s_req_i;
    coef_load_en_n_o <= !c_req_i;
    s_q <= s_val_i;
    c_q <= c_val_i;
    {sample_format_sel_o, sample_in_bus_o} <=
      sample_load_en_n_o ? ~{sample_format_sel_o, sample_in_bus_o} : s_q;
    {coef_format_sel_o, coef_in_bus_o} <= coef_load_en_n_o ? ~{coef_format_sel_o, coef_in_bus_o} : c_q;
  end
endmodule

// File: bench/test_fir_input_load_stage.sv
// self-checking bench for the filter input load stage
`include "filin_defines.svh"
module test_fir_input_load_stage
  import filin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rstn = 1'b0, s_req = 1'b0, c_req = 1'b0, chk_on = 1'b0;
  filin_opnd_t s_val = '0, c_val = '0, exp_c, sv1, sv2, cv1, cv2;
  logic        sp1, sp2, cp1, cp2, s_fmt, s_en_n, c_fmt, c_en_n, hready, hresp;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [7:0]  s_bus, c_bus;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [71:0] exp_s, cells;
  logic [8:0]  coef0;
  int          bad_count = 0, num_checks = 0;
  filin_opnd_t tbl [6] = '{9'h180, 9'h080, 9'h17F, 9'h0FF, 9'h101, 9'h000};

  always #50 clk = ~clk;

  filin_src_model src (.clk_sys_i(clk), .s_req_i(s_req), .s_val_i(s_val), .c_req_i(c_req),
    .c_val_i(c_val), .sample_in_bus_o(s_bus), .sample_format_sel_o(s_fmt),
    .sample_load_en_n_o(s_en_n), .coef_in_bus_o(c_bus), .coef_format_sel_o(c_fmt),
    .coef_load_en_n_o(c_en_n));

  filin_top dut (.clk_sys_i(clk), .rstn_i(rstn), .sample_in_bus_i(s_bus), .sample_format_sel_i(s_fmt),
    .sample_load_en_n_i(s_en_n), .coef_in_bus_i(c_bus), .coef_format_sel_i(c_fmt),
    .coef_load_en_n_i(c_en_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .sample_cells_o(cells), .coef_cell0_o(coef0));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [71:0] e, input logic [71:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single word transfer; only the bound ends a stalled wait
  task automatic bus_xfer(input logic wr, input filin_ofs_t a, input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= `FILIN_HTRANS_NSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= `FILIN_HSIZE_WORD;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    d = hrdata;
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic rd_chk(input filin_ofs_t a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    bus_xfer(1'b0, a, 32'h0, d);
    check(nm, {40'h0, e}, {40'h0, d});
    check({nm, "_hresp"}, 72'h0, {71'h0, hresp});
  endtask

  // reference pipeline: request, enable stage, data stage, load edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sp1, sp2, cp1, cp2} <= 4'h0;
      exp_s <= '0;
      exp_c <= '0;
    end else begin
      sp1 <= s_req;
      sv1 <= s_val;
      sp2 <= sp1;
      sv2 <= sv1;
      cp1 <= c_req;
      cv1 <= c_val;
      cp2 <= cp1;
      cv2 <= cv1;
      exp_s <= sp2 ? {8{sv2}} : '0;
      if (cp2) begin
        exp_c <= cv2;
      end
    end
  end

  always @(negedge clk) begin
    if (chk_on) begin
      check("sample_cells", exp_s, cells);
      check("coef_cell0", exp_c, {63'h0, coef0});
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    chk_on <= 1'b1;
    @(posedge clk);
    rd_chk(`FILIN_OFS_STATUS, 32'h3, "status_reset");
    $display("test reset done");
    // gaps every third cycle force zero loads between back-to-back samples
    for (int i = 0; i < 18; i++) begin
      s_req <= (i % 3 != 2);
      s_val <= tbl[i % 6];
      c_req <= i[0];
      c_val <= ~tbl[i % 6];
      @(posedge clk);
    end
    s_req <= 1'b0;
    c_req <= 1'b0;
    repeat (5) @(posedge clk);
    $display("test stream done");
    s_req <= 1'b1;
    s_val <= 9'h180;
    c_req <= 1'b1;
    c_val <= 9'h07F;
    repeat (4) @(posedge clk);
    bus_xfer(1'b1, `FILIN_OFS_CTRL, 32'h5, rd);
    rd_chk(`FILIN_OFS_CTRL, 32'h5, "ctrl");
    rd_chk(`FILIN_OFS_SVIEW, 32'h180, "sample_view");
    rd_chk(`FILIN_OFS_SVAL, 32'hFFFFFF80, "sample_signed");
    rd_chk(`FILIN_OFS_CVAL, 32'h7F, "coef_unsigned");
    rd_chk(`FILIN_OFS_STATUS, 32'h0, "status_active");
    s_val <= 9'h080;
    c_val <= 9'h1FF;
    repeat (4) @(posedge clk);
    rd_chk(`FILIN_OFS_SVAL, 32'h80, "sample_unsigned");
    rd_chk(`FILIN_OFS_CVAL, 32'hFFFFFFFF, "coef_signed");
    c_req <= 1'b0;
    c_val <= 9'h055;
    bus_xfer(1'b1, `FILIN_OFS_STATUS, 32'h3, rd);
    rd_chk(`FILIN_OFS_CVIEW, 32'h1FF, "coef_hold");
    rd_chk(`FILIN_OFS_STATUS, 32'h2, "status_ro");
    rd_chk(8'h20, 32'h0, "unmapped");
    $display("test registers done");
    give_verdict();
  end
endmodule
